/* File: core/ledi_indicator.sv */
// per-port led indicator: strap mode select and active-low drive
// Operation
// - latch strap at reset, hold mode
// - strap 0000/0001/0010 give modes 0/1/2
// - strap 0011 mode 3; others factory test
// - mode 0 led3 solid on: link, idle
// - mode 0 led3 off without link
// - mode 0 led3 blinks with traffic
// - mode 1 led3 on while receiving
// - mode 2 led3 shows 100 Mb/s activity
// - mode 3 led3 behaves as mode 0
// - mode 1 led1 on for full duplex
// - led0 speed, speed blink, or collision
`timescale 1ns/100ps
module ledi_indicator #(
	parameter int unsigned NP       = ledi_pkg::NPORT,
	parameter int unsigned FAST_CYC = ledi_pkg::FAST_CYC,
	parameter int unsigned SLOW_CYC = ledi_pkg::SLOW_CYC
) (
	// clock and reset
	input  wire logic                   mclk_i,
	input  wire logic                   rst_n_i,
	// reset-time strap pins
	input  wire logic [3:0]             led_mode_strap_i,
	// per-port status from the mac/phy, same clock
	input  wire logic [NP-1:0]          link_up_i,
	input  wire logic [NP-1:0]          speed_100_i,
	input  wire logic [NP-1:0]          full_duplex_i,
	input  wire logic [NP-1:0]          tx_act_i,
	input  wire logic [NP-1:0]          rx_act_i,
	input  wire logic [NP-1:0]          collision_i,
	// register port
	input  wire logic [ledi_pkg::AW-1:0] reg_addr_i,
	input  wire logic [ledi_pkg::DW-1:0] reg_wdata_i,
	input  wire logic                   reg_we_i,
	input  wire logic                   reg_re_i,
	output logic      [ledi_pkg::DW-1:0] reg_rdata_o,
	// active-low indicators, one bit per port
	output logic      [NP-1:0]          led0_n_o,
	output logic      [NP-1:0]          led1_n_o,
	output logic      [NP-1:0]          led2_n_o,
	output logic      [NP-1:0]          led3_n_o
);
	import ledi_pkg::*;

	// four-way pick by mode, used for led0, led2 and led3
	function automatic logic [NP-1:0] ledi_pick(
		input ledi_mode_t    m,
		input logic [NP-1:0] v0,
		input logic [NP-1:0] v1,
		input logic [NP-1:0] v2,
		input logic [NP-1:0] v3
	);
		logic [NP-1:0] r;
		r = v0;
		case (m)
			LEDI_MODE0: r = v0;
			LEDI_MODE1: r = v1;
			LEDI_MODE2: r = v2;
			LEDI_MODE3: r = v3;
			default:    r = v0;
		endcase
		return r;
	endfunction : ledi_pick

	logic [3:0]    strap_w;     // captured strap
	logic          done_w;      // capture taken
	logic          fast_tick_w; // fast half-period end
	logic          fast_ph_w;   // fast blink phase
	logic          slow_tick_w; // slow half-period end
	logic          slow_ph_w;   // slow blink phase
	ledi_mode_t    mode_w;      // decoded led mode
	logic          test_w;      // factory-test strap seen
	logic [1:0]    ctrl_q;      // blank and lamp-test bits
	logic [DW-1:0] rdata_q;     // read data register
	logic [NP-1:0] hold_f_q;    // activity seen this fast period
	logic [NP-1:0] hold_s_q;    // activity seen this slow period
	logic [NP-1:0] act_w;       // any traffic this cycle
	logic [NP-1:0] blink_f_w;   // link lit, fast blink on traffic
	logic [NP-1:0] blink_s_w;   // link lit, slow blink on traffic
	logic [NP-1:0] blink_sp_w;  // blink at each port's own speed
	logic [NP-1:0] on0_w;       // lit request per indicator
	logic [NP-1:0] on1_w;
	logic [NP-1:0] on2_w;
	logic [NP-1:0] on3_w;
	logic          normal_w;    // show status, no override
	logic          lamp_w;      // force everything lit
	logic [NP-1:0] led0_q;
	logic [NP-1:0] led1_q;
	logic [NP-1:0] led2_q;
	logic [NP-1:0] led3_q;
	logic          st_sel_w;    // status address hit
	logic          ct_sel_w;    // control address hit
	logic [DW-1:0] status_w;    // status word

	ledi_strap_latch u_strap (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.strap_i (led_mode_strap_i),
		.strap_o (strap_w),
		.done_o  (done_w)
	);

	// fast blink for 100 Mb/s and general activity
	ledi_blink_timer #(.HALF_CYC(FAST_CYC)) u_fast (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.tick_o  (fast_tick_w),
		.phase_o (fast_ph_w)
	);

	// slow blink for 10 Mb/s
	ledi_blink_timer #(.HALF_CYC(SLOW_CYC)) u_slow (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.tick_o  (slow_tick_w),
		.phase_o (slow_ph_w)
	);

	// low strap bits name the mode
	assign mode_w = ledi_mode_t'(strap_w[1:0]);
	// upper bits only flag factory test, never change mode
	assign test_w = |strap_w[3:2];

	// activity holds: set wins over the period-end clear
	assign act_w = tx_act_i | rx_act_i;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hold_f_q <= '0;
			hold_s_q <= '0;
		end else begin
			hold_f_q <= (hold_f_q & ~{NP{fast_tick_w}}) | act_w;
			hold_s_q <= (hold_s_q & ~{NP{slow_tick_w}}) | act_w;
		end
	end

	// lit on link, dark in blink phase while busy
	assign blink_f_w = link_up_i & ~(hold_f_q & {NP{fast_ph_w}});
	assign blink_s_w = link_up_i & ~(hold_s_q & {NP{slow_ph_w}});

	// rate chosen bit by bit: one fast port must not speed up the rest
	assign blink_sp_w = (speed_100_i & blink_f_w) | (~speed_100_i & blink_s_w);
	assign on0_w = ledi_pick(mode_w, link_up_i & speed_100_i,
		blink_sp_w, collision_i,
		link_up_i & speed_100_i);
	assign on1_w = link_up_i & full_duplex_i;
	// third indicator: collision, transmit, link, duplex
	assign on2_w = ledi_pick(mode_w, collision_i, tx_act_i, link_up_i,
		link_up_i & full_duplex_i);
	assign on3_w = ledi_pick(mode_w, blink_f_w, rx_act_i,
		blink_f_w & speed_100_i, blink_f_w);

	// dark until the strap is taken, so no stray mode shows
	assign normal_w = done_w & ~ctrl_q[CT_BLANK_BIT] & ~ctrl_q[CT_LAMP_BIT];
	assign lamp_w   = done_w & ctrl_q[CT_LAMP_BIT];

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			led0_q <= '1;
			led1_q <= '1;
			led2_q <= '1;
			led3_q <= '1;
		end else begin
			led0_q <= ~((on0_w & {NP{normal_w}}) | {NP{lamp_w}});
			led1_q <= ~((on1_w & {NP{normal_w}}) | {NP{lamp_w}});
			led2_q <= ~((on2_w & {NP{normal_w}}) | {NP{lamp_w}});
			led3_q <= ~((on3_w & {NP{normal_w}}) | {NP{lamp_w}});
		end
	end

	assign led0_n_o = led0_q;
	assign led1_n_o = led1_q;
	assign led2_n_o = led2_q;
	assign led3_n_o = led3_q;

	// register decode
	assign st_sel_w = (reg_addr_i == REG_STATUS);
	assign ct_sel_w = (reg_addr_i == REG_CTRL);
	assign status_w = DW'({done_w, test_w, 2'h0, 2'(mode_w), strap_w});

	// control register write
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_q <= CTRL_RST;
		end else if (reg_we_i && ct_sel_w) begin
			ctrl_q <= reg_wdata_i[1:0];
		end
	end

	// read data one cycle later, zero elsewhere and on unmapped
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_q <= '0;
		end else if (reg_re_i && st_sel_w) begin
			rdata_q <= status_w;
		end else if (reg_re_i && ct_sel_w) begin
			rdata_q <= DW'(ctrl_q);
		end else begin
			rdata_q <= '0;
		end
	end

	assign reg_rdata_o = rdata_q;

	// checks
	property p_mode_hold;
		@(posedge mclk_i) disable iff (!rst_n_i)
		done_w |=> done_w && $stable(strap_w);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed after capture");

	property p_decode;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(strap_w == 4'h2) |-> (mode_w == LEDI_MODE2) && !test_w;
	endproperty
	a_decode: assert property (p_decode) else $error("strap 0010 not mode 2");

	property p_decode3;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(strap_w == 4'h3) |-> (mode_w == LEDI_MODE3);
	endproperty
	a_decode3: assert property (p_decode3) else $error("strap 0011 not mode 3");

	property p_m0_solid;
		@(posedge mclk_i) disable iff (!rst_n_i)
		normal_w && mode_w == LEDI_MODE0 && link_up_i[0] && !hold_f_q[0] |=> !led3_n_o[0];
	endproperty
	a_m0_solid: assert property (p_m0_solid) else $error("idle link led3 not lit");

	property p_m0_off;
		@(posedge mclk_i) disable iff (!rst_n_i)
		normal_w && mode_w == LEDI_MODE0 && !link_up_i[0] |=> led3_n_o[0];
	endproperty
	a_m0_off: assert property (p_m0_off) else $error("no link but led3 lit");

	property p_m0_blink;
		@(posedge mclk_i) disable iff (!rst_n_i)
		normal_w && mode_w == LEDI_MODE0 && hold_f_q[0] && fast_ph_w |=> led3_n_o[0];
	endproperty
	a_m0_blink: assert property (p_m0_blink) else $error("busy led3 not dark in phase");

	property p_m1_rx;
		@(posedge mclk_i) disable iff (!rst_n_i)
		normal_w && mode_w == LEDI_MODE1 |=> led3_n_o[0] == !$past(rx_act_i[0]);
	endproperty
	a_m1_rx: assert property (p_m1_rx) else $error("led3 not following receive");

	property p_m2_speed;
		@(posedge mclk_i) disable iff (!rst_n_i)
		normal_w && mode_w == LEDI_MODE2 && !speed_100_i[0] |=> led3_n_o[0];
	endproperty
	a_m2_speed: assert property (p_m2_speed) else $error("led3 lit at 10 Mb/s");

	property p_m3_solid;
		@(posedge mclk_i) disable iff (!rst_n_i)
		normal_w && mode_w == LEDI_MODE3 && link_up_i[0] && !hold_f_q[0] |=> !led3_n_o[0];
	endproperty
	a_m3_solid: assert property (p_m3_solid) else $error("mode 3 idle led3 not lit");

	property p_m1_dup;
		@(posedge mclk_i) disable iff (!rst_n_i)
		normal_w && mode_w == LEDI_MODE1 && link_up_i[0] |=> led1_n_o[0] == !$past(full_duplex_i[0]);
	endproperty
	a_m1_dup: assert property (p_m1_dup) else $error("duplex led wrong");

	property p_m2_col;
		@(posedge mclk_i) disable iff (!rst_n_i)
		normal_w && mode_w == LEDI_MODE2 && collision_i[0] |=> !led0_n_o[0];
	endproperty
	a_m2_col: assert property (p_m2_col) else $error("collision led not lit");

	property p_m1_slow;
		@(posedge mclk_i) disable iff (!rst_n_i)
		normal_w && mode_w == LEDI_MODE1 && !speed_100_i[0] && hold_s_q[0] && slow_ph_w |=> led0_n_o[0];
	endproperty
	a_m1_slow: assert property (p_m1_slow) else $error("10 Mb/s led0 not dark in slow phase");

	property p_m1_slow_on;
		@(posedge mclk_i) disable iff (!rst_n_i)
		normal_w && mode_w == LEDI_MODE1 && link_up_i[0] && !speed_100_i[0] && !slow_ph_w |=> !led0_n_o[0];
	endproperty
	a_m1_slow_on: assert property (p_m1_slow_on) else $error("10 Mb/s led0 dark in lit phase");

	property p_lamp;
		@(posedge mclk_i) disable iff (!rst_n_i)
		lamp_w |=> !(|led0_n_o) && !(|led1_n_o) && !(|led2_n_o) && !(|led3_n_o);
	endproperty
	a_lamp: assert property (p_lamp) else $error("lamp test left a led dark");

	property p_dark;
		@(posedge mclk_i) disable iff (!rst_n_i)
		!done_w |=> (&led0_n_o) && (&led1_n_o) && (&led2_n_o) && (&led3_n_o);
	endproperty
	a_dark: assert property (p_dark) else $error("led lit before capture");

	// main scenarios
	c_m0_blink: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
		normal_w && mode_w == LEDI_MODE0 && hold_f_q[0] && fast_ph_w);
	c_m1_rx: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
		normal_w && mode_w == LEDI_MODE1 && rx_act_i[0]);
	c_m2_col: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
		normal_w && mode_w == LEDI_MODE2 && collision_i[0]);
	c_test: cover property (@(posedge mclk_i) disable iff (!rst_n_i) done_w && test_w);
	c_m1_slow: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
		normal_w && mode_w == LEDI_MODE1 && !speed_100_i[0] && hold_s_q[0] && slow_ph_w);
endmodule : ledi_indicator

/* File: core/ledi_pkg.sv */
// package for the per-port led indicator block: constants and modes
package ledi_pkg;
	// number of switch ports served
	localparam int unsigned NPORT        = 9;
	// core clock period in ns (100 MHz)
	localparam int unsigned CLK_NS       = 10;
	// blink half periods in ns
	localparam int unsigned FAST_HALF_NS = 50_000_000;
	localparam int unsigned SLOW_HALF_NS = 200_000_000;
	// longest times round down to whole cycles
	localparam int unsigned FAST_CYC     = FAST_HALF_NS / CLK_NS;
	localparam int unsigned SLOW_CYC     = SLOW_HALF_NS / CLK_NS;
	// edges after reset release before the strap is captured
	localparam logic [1:0]  STRAP_WAIT   = 2'h2;
	// register port
	localparam int unsigned AW           = 4;
	localparam int unsigned DW           = 32;
	localparam logic [3:0]  REG_STATUS   = 4'h0;
	localparam logic [3:0]  REG_CTRL     = 4'h4;
	// status fields
	localparam int unsigned ST_STRAP_LSB = 0;
	localparam int unsigned ST_MODE_LSB  = 4;
	localparam int unsigned ST_TEST_BIT  = 8;
	localparam int unsigned ST_DONE_BIT  = 9;
	// control fields and reset value
	localparam int unsigned CT_BLANK_BIT = 0;
	localparam int unsigned CT_LAMP_BIT  = 1;
	localparam logic [1:0]  CTRL_RST     = 2'h0;
	// led modes, encoded as the low strap bits
	typedef enum logic [1:0] {
		LEDI_MODE0,
		LEDI_MODE1,
		LEDI_MODE2,
		LEDI_MODE3
	} ledi_mode_t;
endpackage : ledi_pkg

/* File: core/ledi_strap_latch.sv */
// strap synchroniser and one-shot capture after reset release
`timescale 1ns/100ps
module ledi_strap_latch (
	// clock and reset
	input  wire logic       mclk_i,
	input  wire logic       rst_n_i,
	// strap pins
	input  wire logic [3:0] strap_i,
	// captured value
	output logic      [3:0] strap_o,
	output logic            done_o
);
	import ledi_pkg::*;

	logic [3:0] sync1_q;  // first stage, read only by sync2
	logic [3:0] sync2_q;  // second stage
	logic [1:0] wait_q;   // edges since release
	logic [3:0] strap_q;  // captured strap
	logic       done_q;   // capture taken

	// two-flop synchroniser on the strap pins
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1_q <= 4'h0;
			sync2_q <= 4'h0;
		end else begin
			sync1_q <= strap_i;
			sync2_q <= sync1_q;
		end
	end

	// capture once, after the synchroniser has filled; held until reset
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wait_q  <= 2'h0;
			strap_q <= 4'h0;
			done_q  <= 1'b0;
		end else if (!done_q) begin
			if (wait_q == STRAP_WAIT) begin
				strap_q <= sync2_q;
				done_q  <= 1'b1;
			end else begin
				wait_q <= wait_q + 2'h1;
			end
		end
	end

	assign strap_o = strap_q;
	assign done_o  = done_q;
endmodule : ledi_strap_latch

/* File: core/ledi_blink_timer.sv */
// free-running blink timer: tick pulse and toggling phase
`timescale 1ns/100ps
module ledi_blink_timer #(
	parameter int unsigned HALF_CYC = 4
) (
	// clock and reset
	input  wire logic mclk_i,
	input  wire logic rst_n_i,
	// timer outputs
	output logic      tick_o,
	output logic      phase_o
);
	localparam int unsigned CW = $clog2(HALF_CYC + 1);
	localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

	logic [CW-1:0] cnt_q;    // cycle count in this half period
	logic          tick_q;   // one-cycle end of half period
	logic          phase_q;  // blink phase, high means dark

	// count half periods; phase flips with each tick
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q   <= '0;
			tick_q  <= 1'b0;
			phase_q <= 1'b0;
		end else begin
			tick_q <= (cnt_q == LAST);
			cnt_q  <= (cnt_q == LAST) ? '0 : cnt_q + CW'(1);
			if (tick_q) begin
				phase_q <= ~phase_q;
			end
		end
	end

	assign tick_o  = tick_q;
	assign phase_o = phase_q;
endmodule : ledi_blink_timer

/* File: tb/ledi_board.sv */
// board model: strap resistors and index-3 lamps
`timescale 1ns/100ps
module ledi_board #(
	parameter int unsigned NP = 9
) (
	// strap choice from the bench
	input  wire logic [3:0]    sel_i,
	input  wire logic          test_i,
	// strap pins into the device
	output logic      [3:0]    strap_o,
	// indicator pins and lamp state
	input  wire logic [NP-1:0] led3_n_i,
	output logic      [NP-1:0] lit_o
);
	// upper bits held low
	// only a factory test fit lets them rise
	assign strap_o = {sel_i[3:2] & {2{test_i}}, sel_i[1:0]};
	assign lit_o = ~led3_n_i;
endmodule : ledi_board

/* File: tb/tb_ledi_indicator.sv */
// testbench for the led indicator block
`timescale 1ns/100ps
module tb_ledi_indicator;
	import ledi_pkg::*;
	localparam int unsigned NP = NPORT;
	// clock, reset, strap choice
	logic          mclk_i = 0, rst_n_i = 0, re_d = 0, chk = 0, tst = 0;
	logic [3:0]    sel = 0, strap, s;
	// per-port status and indicators
	logic [NP-1:0] link = 0, spd = 0, fdx = 0, tx = 0, rx = 0, col = 0, lit;
	logic [NP-1:0] l0_n, l1_n, l2_n, l3_n;
	// register port
	logic [AW-1:0] addr = 0;
	logic [DW-1:0] wdata = 0, rdata;
	logic          we = 0, re = 0;
	// expectation notes and counters
	logic [DW-1:0] rq[$];
	logic [35:0]   lq[$];
	int            bad_count = 0, checks_done = 0, dk, lt, on3, nc;
	logic          bl = 0, bp = 0;
	logic [3:0]    straps [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h7};

	always #5 mclk_i = ~mclk_i;

	ledi_indicator #(.NP(NP), .FAST_CYC(4), .SLOW_CYC(8)) i_ledi_indicator (
		.mclk_i(mclk_i), .rst_n_i(rst_n_i), .led_mode_strap_i(strap),
		.link_up_i(link), .speed_100_i(spd), .full_duplex_i(fdx),
		.tx_act_i(tx), .rx_act_i(rx), .collision_i(col),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
		.reg_rdata_o(rdata), .led0_n_o(l0_n), .led1_n_o(l1_n),
		.led2_n_o(l2_n), .led3_n_o(l3_n));

	ledi_board #(.NP(NP)) i_ledi_board (
		.sel_i(sel), .test_i(tst), .strap_o(strap), .led3_n_i(l3_n), .lit_o(lit));

	// verdict and end of run
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test

	// compare tasks, one per result kind
	task automatic cmp_rd(input logic [DW-1:0] e);
		checks_done++;
		if (rdata !== e) begin
			bad_count++;
			$display("mismatch %0t read %h expected %h", $time, rdata, e);
		end
	endtask : cmp_rd
	task automatic cmp_led(input logic [35:0] e);
		checks_done++;
		if ({l3_n, l2_n, l1_n, l0_n} !== e) begin
			bad_count++;
			$display("mismatch %0t leds %h expected %h", $time, {l3_n, l2_n, l1_n, l0_n}, e);
		end
	endtask : cmp_led
	task automatic cmp_flag(input bit ok, input string m);
		checks_done++;
		if (!ok) begin
			bad_count++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask : cmp_flag

	// bus steps: each sets every strobe once per edge
	task automatic acc(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge mclk_i);
		we <= w;
		re <= !w;
		chk <= 1'b0;
		addr <= a;
		wdata <= d;
		// read data is the note for the monitor
		if (!w) rq.push_back(d);
	endtask : acc
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge mclk_i);
			we <= 1'b0;
			re <= 1'b0;
			chk <= 1'b0;
		end
	endtask : idle
	task automatic lchk(input logic [35:0] e);
		@(posedge mclk_i);
		we <= 1'b0;
		re <= 1'b0;
		chk <= 1'b1;
		lq.push_back(e);
	endtask : lchk

	// expected indicator levels for a steady, idle port set
	function automatic logic [35:0] expv(input logic [1:0] m);
		logic [NP-1:0] v0, v2, v3;
		case (m)
			2'h0: begin
				v0 = link & spd; v2 = col; v3 = link;
			end
			2'h1: begin
				v0 = link; v2 = tx; v3 = rx;
			end
			2'h2: begin
				v0 = col; v2 = link; v3 = link & spd;
			end
			default: begin
				v0 = link & spd; v2 = fdx & link; v3 = link;
			end
		endcase
		return ~{v3, v2, fdx & link, v0};
	endfunction : expv

	// monitor: a result pops the oldest note
	always @(posedge mclk_i) begin
		re_d <= re;
		if (re_d) cmp_rd(rq.pop_front());
		if (chk) cmp_led(lq.pop_front());
	end

	// hang guard
	initial begin
		repeat (100000) @(posedge mclk_i);
		bad_count++;
		$display("mismatch %0t run too long", $time);
		finish_test();
	end

	// main sequence: one reset per strap value
	initial begin
		void'($urandom(16));
		foreach (straps[k]) begin
			s = straps[k];
			rst_n_i <= 1'b0;
			sel <= s;
			tst <= |s[3:2];
			idle(2);
			lchk('1);
			idle(18);
			rst_n_i <= 1'b1;
			idle(6);
			// strap pins move after capture, mode must hold
			sel <= ~s;
			acc(0, REG_CTRL, '0);
			acc(0, REG_STATUS, 32'h200 | (DW'(|s[3:2]) << 8) | (DW'(s[1:0]) << 4) | DW'(s));
			link <= NP'($urandom);
			spd <= NP'($urandom);
			fdx <= NP'($urandom);
			col <= NP'($urandom);
			idle(4);
			lchk(expv(s[1:0]));
			link <= '1;
			spd <= {{(NP-1){1'b1}}, 1'b0};
			tx <= '1;
			rx <= '1;
			dk = 0;
			lt = 0;
			on3 = 0;
			nc = 0;
			// traffic, port 0 at 10 Mb/s: count dark, lit and changed samples
			repeat (32) begin
				idle(1);
				#1;
				bp = bl;
				// mode 1 watches the slow led0 blink, mode 2 the 100 Mb/s port
				if (s[1:0] == 2'h1) bl = l0_n[0];
				else if (s[1:0] == 2'h2) bl = l3_n[1];
				else bl = l3_n[0];
				if (bl === 1'b1) dk++;
				if (bl === 1'b0) lt++;
				if (dk + lt > 1 && bl !== bp) nc++;
				if (lit[0] === 1'b1) on3++;
			end
			cmp_flag(dk > 0 && lt > 0 && dk + lt == 32, "no blink with traffic");
			if (s[1:0] == 2'h1) cmp_flag(on3 == 32, "receive lamp not steady");
			if (s[1:0] == 2'h1) cmp_flag(nc <= 5, "10 Mb/s blink too fast");
			else cmp_flag(nc >= 6, "activity blink too slow");
			if (s[1:0] == 2'h2) cmp_flag(on3 == 0, "led3 lit at 10 Mb/s");
			@(posedge mclk_i);
			tx <= '0;
			rx <= '0;
			// lamp test, blank, unmapped place, back to back
			acc(1, REG_CTRL, 32'h2);
			idle(3);
			lchk('0);
			acc(1, REG_CTRL, 32'h1);
			acc(1, 4'h8, 32'hFFFFFFFF);
			acc(0, REG_CTRL, 32'h1);
			acc(0, 4'h8, 32'h0);
			idle(2);
			lchk('1);
			acc(1, REG_CTRL, 32'h0);
			idle(3);
		end
		finish_test();
	end
endmodule : tb_ledi_indicator
